// >>> pkg/hvpp_params.svh
`ifndef HVPP_PARAMS_SVH
`define HVPP_PARAMS_SVH
// clock and entry timing
`define HVPP_CLK_PERIOD_NS 10
`define HVPP_T_ENTRY_NS    10000
`define HVPP_ENTRY_CYC     ((`HVPP_T_ENTRY_NS + `HVPP_CLK_PERIOD_NS - 1) / `HVPP_CLK_PERIOD_NS)
`define HVPP_PROG_CYC      16
// load action codes
`define HVPP_ACT_ADDR 2'h0
`define HVPP_ACT_DATA 2'h1
`define HVPP_ACT_CMD  2'h2
// command bytes
`define HVPP_CMD_NOP      8'h00
`define HVPP_CMD_ERASE    8'h80
`define HVPP_CMD_WR_FUSE  8'h40
`define HVPP_CMD_WR_LOCK  8'h20
`define HVPP_CMD_WR_FLASH 8'h10
`define HVPP_CMD_WR_EE    8'h11
`define HVPP_CMD_RD_SIG   8'h08
`define HVPP_CMD_RD_FUSE  8'h04
`define HVPP_CMD_RD_FLASH 8'h02
`define HVPP_CMD_RD_EE    8'h03
// reset values of fuse and lock bytes
`define HVPP_FUSE_LO_RST  8'h62
`define HVPP_FUSE_HI_RST  8'hdf
`define HVPP_FUSE_EXT_RST 8'hf9
`define HVPP_LOCK_RST     8'hff
`define HVPP_FUSE_HI_PRESERVE_BIT 3
`endif

// >>> pkg/hvpp_pkg.sv
package hvpp_pkg;
	// synchronised pin group
	typedef struct packed {
		logic       hv;     // high voltage on reset
		logic       xtal;   // load pulse
		logic       xa1;    // action bit 1
		logic       xa0;    // action bit 0
		logic       bs1;    // byte select lo/hi
		logic       bs2;    // byte select ext
		logic       page_buffer_latch;  // page latch
		logic       wr_n;   // write strobe
		logic       oe_n;   // output enable
		logic [7:0] data;   // data bus in
	} hvpp_pins_type;
	// programming mode states
	typedef enum logic [1:0] {MODE_OFF, MODE_ENTRY, MODE_ACTIVE} hvpp_mode_type;
	// internal operations
	typedef enum logic [2:0] {OP_NONE, OP_ERASE, OP_LOCKCLR, OP_PAGE, OP_EEPAGE, OP_WAIT} hvpp_op_type;
endpackage : hvpp_pkg

// >>> hdl/hvpp_port.sv
// Notes on behaviour
// - load pulse decodes action: addr, data, command
// - write/read strobes act on held command
// - decode erase, fuse, lock, flash, eeprom writes
// - decode signature, fuse, flash, eeprom reads
// - ready low while internal operation runs
// - byte selects choose low/high/extended byte
// - bus driven only while output enable low
// - page latch moves data word to buffer
// - entry signature zero, held 10 us
// - command and address kept across operations
// - address high byte holds until reloaded
// - erase clears memories, keeps fuses, preserve fuse
// - locks cleared only after flash erased
// - erase starts on write, ready low
// - flash page buffered, written in one go
// - data load selects low or high byte
// - low address bits word, upper bits page
// - address load selects low or high byte
// - write strobe programs page, ready low
// - no-operation command clears write state
`include "hvpp_params.svh"
module hvpp_port #(
	parameter int FLASH_AW = 13,        // flash word address bits
	parameter int PW_AW    = 6,         // word-in-page bits
	parameter int EE_AW    = 9,         // eeprom address bits
	parameter int EP_AW    = 2,         // byte-in-eeprom-page bits
	parameter logic [7:0] SIG0 = 8'h5a, // signature byte 0, arbitrary value
	parameter logic [7:0] SIG1 = 8'h01, // signature byte 1, arbitrary value
	parameter logic [7:0] SIG2 = 8'h02, // signature byte 2, arbitrary value
	parameter logic [7:0] CAL  = 8'h80  // calibration byte, arbitrary value
) (
	input  wire logic       clock_i,             // 100 MHz clock
	input  wire logic       rst_n_i,             // sync reset, active low
	input  wire logic       clk_en_i,            // freezes all state when low
	input  wire logic       hv_reset_i,          // high voltage present on reset
	input  wire logic       load_pulse_in_i,     // load pulse, rising edge
	input  wire logic       load_action_bit0_i,  // action select bit 0
	input  wire logic       load_action_bit1_i,  // action select bit 1
	input  wire logic       byte_select_lo_hi_i, // 0 low, 1 high byte
	input  wire logic       byte_select_ext_i,   // 1 second high byte
	input  wire logic       page_buffer_latch_i, // page latch, rising edge
	input  wire logic       write_n_i,           // write strobe, active low
	input  wire logic       out_en_n_i,          // output enable, active low
	input  wire logic [7:0] data_i,              // data bus in
	output logic      [7:0] data_o,              // data bus out
	output logic            data_oe_o,           // data bus drive enable
	output logic            ready_busy_out_o,    // 1 ready, 0 busy
	output logic            prog_mode_o,         // programming mode active
	output logic            eeprom_preserve_fuse_o // 0 when preserve programmed
);
	localparam int FE_W = 1 + PW_AW + 16;       // fifo entry width
	localparam int PAGE_WORDS = 1 << PW_AW;     // flash page size
	localparam int EE_PAGE = 1 << EP_AW;        // eeprom page size
	localparam int FLASH_WORDS = 1 << FLASH_AW; // flash size
	localparam int EE_BYTES = 1 << EE_AW;       // eeprom size
	localparam int CNT_W = (FLASH_AW > EE_AW) ? FLASH_AW : EE_AW; // walk counter bits
	localparam int ERASE_LAST = (1 << CNT_W) - 1;                 // last erase step

	// whole control state
	typedef struct packed {
		hvpp_pkg::hvpp_pins_type   s1;       // first sync stage
		hvpp_pkg::hvpp_pins_type   s2;       // second sync stage
		hvpp_pkg::hvpp_pins_type   prev;     // delayed for edges
		hvpp_pkg::hvpp_mode_type   mode;     // programming mode state
		logic [15:0]               ent_cnt;  // entry hold counter
		logic [7:0]                cmd;      // command byte
		logic [7:0]                addr_hi;  // address high byte
		logic [7:0]                addr_lo;  // address low byte
		logic [7:0]                dat_lo;   // data low byte
		logic [7:0]                dat_hi;   // data high byte
		logic [7:0]                fuse_lo;  // low fuse byte
		logic [7:0]                fuse_hi;  // high fuse byte
		logic [7:0]                fuse_ext; // extended fuse byte
		logic [7:0]                lock;     // lock byte
		hvpp_pkg::hvpp_op_type     op;       // running operation
		logic [CNT_W-1:0]          cnt;      // walk counter
		logic [15:0]               wait_cnt; // program time counter
		logic [1:0][FE_W-1:0]      fifo;     // two-entry latch buffer
		logic                      wp;       // fifo write pointer
		logic                      rp;       // fifo read pointer
		logic [1:0]                fcnt;     // fifo fill level
		logic [7:0]                rdata;    // read data register
		logic                      oe;       // bus drive register
	} hvpp_state_type;

	hvpp_state_type          r;          // current state
	hvpp_state_type          next_r;     // next state
	hvpp_pkg::hvpp_pins_type pins_in;    // raw pins
	logic [15:0]       flash [FLASH_WORDS]; // flash array
	logic [7:0]        eep [EE_BYTES];      // eeprom array
	logic [15:0]       pbuf [PAGE_WORDS];   // flash page buffer
	logic [7:0]        ebuf [EE_PAGE];      // eeprom page buffer
	logic              fl_we, ee_we, pb_we, eb_we; // array write strobes
	logic [FLASH_AW-1:0] fl_wa;             // flash write address
	logic [15:0]       fl_wd;               // flash write data
	logic [EE_AW-1:0]  ee_wa;               // eeprom write address
	logic [7:0]        ee_wd;               // eeprom write data
	logic [PW_AW-1:0]  pb_wa;               // buffer write index
	logic [15:0]       pb_wd;               // buffer write data
	logic [15:0]       addr;                // full address
	logic xtal_rise, wr_fall, page_buffer_latch_rise, push, pop, nop_load; // events
	logic [FE_W-1:0]   head;                // fifo head entry

	assign pins_in = {hv_reset_i, load_pulse_in_i, load_action_bit1_i, load_action_bit0_i,
		byte_select_lo_hi_i, byte_select_ext_i, page_buffer_latch_i, write_n_i, out_en_n_i,
		data_i};
	assign addr = {r.addr_hi, r.addr_lo};
	assign head = r.fifo[r.rp];
	assign xtal_rise = r.s2.xtal & ~r.prev.xtal;
	assign wr_fall = ~r.s2.wr_n & r.prev.wr_n;
	assign page_buffer_latch_rise = r.s2.page_buffer_latch & ~r.prev.page_buffer_latch;
	// command load of the no-operation byte
	assign nop_load = xtal_rise && (r.mode == hvpp_pkg::MODE_ACTIVE)
		&& ({r.s2.xa1, r.s2.xa0} == `HVPP_ACT_CMD) && (r.s2.data == `HVPP_CMD_NOP);
	// busy while operating or buffer full
	assign ready_busy_out_o = (r.op == hvpp_pkg::OP_NONE) && (r.fcnt != 2'h2);
	assign data_o = r.rdata;
	assign data_oe_o = r.oe;
	assign prog_mode_o = (r.mode == hvpp_pkg::MODE_ACTIVE);
	assign eeprom_preserve_fuse_o = r.fuse_hi[`HVPP_FUSE_HI_PRESERVE_BIT];

	// next-state logic
	always_comb begin
		next_r = r;
		fl_we = 1'b0;
		fl_wa = '0;
		fl_wd = '0;
		ee_we = 1'b0;
		ee_wa = '0;
		ee_wd = '0;
		pb_we = 1'b0;
		eb_we = 1'b0;
		pb_wa = '0;
		pb_wd = '0;
		push = 1'b0;
		pop = 1'b0;
		next_r.s1 = pins_in;
		next_r.s2 = r.s1;
		next_r.prev = r.s2;
		case (r.mode)
			hvpp_pkg::MODE_OFF: begin
				if (r.s2.hv && !r.prev.hv && {r.s2.page_buffer_latch, r.s2.xa1, r.s2.xa0, r.s2.bs1} == 4'h0) begin
					next_r.mode = hvpp_pkg::MODE_ENTRY;
					next_r.ent_cnt = '0;
				end
			end
			hvpp_pkg::MODE_ENTRY: begin
				if (!r.s2.hv || {r.s2.page_buffer_latch, r.s2.xa1, r.s2.xa0, r.s2.bs1} != 4'h0) begin
					next_r.mode = hvpp_pkg::MODE_OFF;
				end else if (r.ent_cnt == 16'(`HVPP_ENTRY_CYC - 1)) begin
					next_r.mode = hvpp_pkg::MODE_ACTIVE;
				end else begin
					next_r.ent_cnt = r.ent_cnt + 16'h1;
				end
			end
			hvpp_pkg::MODE_ACTIVE: begin
				if (!r.s2.hv) begin
					next_r.mode = hvpp_pkg::MODE_OFF;
				end
				if (xtal_rise) begin
					case ({r.s2.xa1, r.s2.xa0})
						`HVPP_ACT_ADDR: begin
							// address byte select; high byte held otherwise
							if (r.s2.bs1) next_r.addr_hi = r.s2.data;
							else next_r.addr_lo = r.s2.data;
						end
						`HVPP_ACT_DATA: begin
							if (r.s2.bs1) next_r.dat_hi = r.s2.data;
							else next_r.dat_lo = r.s2.data;
						end
						`HVPP_ACT_CMD: begin
							next_r.cmd = r.s2.data;
						end
						default: begin
						end
					endcase
				end
				if (wr_fall && r.op == hvpp_pkg::OP_NONE) begin
					case (r.cmd)
						`HVPP_CMD_ERASE: begin
							next_r.op = hvpp_pkg::OP_ERASE;
							next_r.cnt = '0;
						end
						`HVPP_CMD_WR_FUSE: begin
							if (r.s2.bs2) next_r.fuse_ext = r.dat_lo;
							else if (r.s2.bs1) next_r.fuse_hi = r.dat_lo;
							else next_r.fuse_lo = r.dat_lo;
							next_r.op = hvpp_pkg::OP_WAIT;
							next_r.wait_cnt = '0;
						end
						`HVPP_CMD_WR_LOCK: begin
							// lock bits can only be programmed
							next_r.lock = r.lock & r.dat_lo;
							next_r.op = hvpp_pkg::OP_WAIT;
							next_r.wait_cnt = '0;
						end
						`HVPP_CMD_WR_FLASH: begin
							next_r.op = hvpp_pkg::OP_PAGE;
							next_r.cnt = '0;
						end
						`HVPP_CMD_WR_EE: begin
							next_r.op = hvpp_pkg::OP_EEPAGE;
							next_r.cnt = '0;
						end
						default: begin
						end
					endcase
				end
				if (page_buffer_latch_rise && r.fcnt != 2'h2) begin
					push = 1'b1;
					next_r.fifo[r.wp] = {r.cmd == `HVPP_CMD_WR_EE, addr[PW_AW-1:0],
						r.dat_hi, r.dat_lo};
					next_r.wp = ~r.wp;
				end
			end
			default: begin
				next_r.mode = hvpp_pkg::MODE_OFF;
			end
		endcase
		// buffer drains into page buffer, stalled during copy
		if (r.fcnt != 2'h0 && r.op != hvpp_pkg::OP_PAGE && r.op != hvpp_pkg::OP_EEPAGE
			&& !nop_load) begin
			pop = 1'b1;
			pb_wa = head[FE_W-2 -: PW_AW];
			pb_wd = head[15:0];
			pb_we = ~head[FE_W-1];
			eb_we = head[FE_W-1];
			next_r.rp = ~r.rp;
		end
		// no-operation empties the latch buffer, pointers kept in step
		if (nop_load) begin
			next_r.fcnt = 2'h0;
			next_r.wp = 1'b0;
			next_r.rp = 1'b0;
		end else begin
			next_r.fcnt = 2'(r.fcnt + {1'b0, push} - {1'b0, pop});
		end
		// internal operation walk
		case (r.op)
			hvpp_pkg::OP_ERASE: begin
				// flash cleared, eeprom cleared unless preserve programmed, fuses kept
				// walk spans the larger of flash and eeprom
				fl_we = 32'(r.cnt) < FLASH_WORDS;
				fl_wa = r.cnt[FLASH_AW-1:0];
				fl_wd = 16'hffff;
				ee_we = (32'(r.cnt) < EE_BYTES) && r.fuse_hi[`HVPP_FUSE_HI_PRESERVE_BIT];
				ee_wa = r.cnt[EE_AW-1:0];
				ee_wd = 8'hff;
				next_r.cnt = r.cnt + 1'b1;
				if (32'(r.cnt) == ERASE_LAST) next_r.op = hvpp_pkg::OP_LOCKCLR;
			end
			hvpp_pkg::OP_LOCKCLR: begin
				next_r.lock = `HVPP_LOCK_RST;
				next_r.op = hvpp_pkg::OP_WAIT;
				next_r.wait_cnt = '0;
			end
			hvpp_pkg::OP_PAGE: begin
				fl_we = 1'b1;
				fl_wa = {addr[FLASH_AW-1:PW_AW], r.cnt[PW_AW-1:0]};
				fl_wd = pbuf[r.cnt[PW_AW-1:0]];
				next_r.cnt = r.cnt + 1'b1;
				if (32'(r.cnt) == PAGE_WORDS - 1) begin
					next_r.op = hvpp_pkg::OP_WAIT;
					next_r.wait_cnt = '0;
				end
			end
			hvpp_pkg::OP_EEPAGE: begin
				ee_we = 1'b1;
				ee_wa = {addr[EE_AW-1:EP_AW], r.cnt[EP_AW-1:0]};
				ee_wd = ebuf[r.cnt[EP_AW-1:0]];
				next_r.cnt = r.cnt + 1'b1;
				if (32'(r.cnt) == EE_PAGE - 1) begin
					next_r.op = hvpp_pkg::OP_WAIT;
					next_r.wait_cnt = '0;
				end
			end
			hvpp_pkg::OP_WAIT: begin
				next_r.wait_cnt = r.wait_cnt + 16'h1;
				if (r.wait_cnt == 16'(`HVPP_PROG_CYC - 1)) next_r.op = hvpp_pkg::OP_NONE;
			end
			default: begin
			end
		endcase
		if (r.mode != hvpp_pkg::MODE_ACTIVE) next_r.op = hvpp_pkg::OP_NONE;
		case (r.cmd)
			`HVPP_CMD_RD_SIG: begin
				if (r.s2.bs1) next_r.rdata = CAL;
				else if (r.addr_lo[1:0] == 2'h0) next_r.rdata = SIG0;
				else if (r.addr_lo[1:0] == 2'h1) next_r.rdata = SIG1;
				else next_r.rdata = SIG2;
			end
			`HVPP_CMD_RD_FUSE: begin
				// selects map fuse and lock bytes
				case ({r.s2.bs2, r.s2.bs1})
					2'h0: next_r.rdata = r.fuse_lo;
					2'h3: next_r.rdata = r.fuse_hi;
					2'h2: next_r.rdata = r.fuse_ext;
					default: next_r.rdata = r.lock;
				endcase
			end
			`HVPP_CMD_RD_FLASH: begin
				next_r.rdata = r.s2.bs1 ? flash[addr[FLASH_AW-1:0]][15:8] : flash[addr[FLASH_AW-1:0]][7:0];
			end
			`HVPP_CMD_RD_EE: next_r.rdata = eep[addr[EE_AW-1:0]];
			default: next_r.rdata = 8'h00;
		endcase
		// drive only with output enable low; release otherwise
		next_r.oe = (r.mode == hvpp_pkg::MODE_ACTIVE) && !r.s2.oe_n;
	end

	// state register
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			r <= '0;
			// idle pin levels: strobes high, pulses and high voltage low
			r.s1 <= 17'h00300;
			r.s2 <= 17'h00300;
			r.prev <= 17'h00300;
			r.fuse_lo <= `HVPP_FUSE_LO_RST;
			r.fuse_hi <= `HVPP_FUSE_HI_RST;
			r.fuse_ext <= `HVPP_FUSE_EXT_RST;
			r.lock <= `HVPP_LOCK_RST;
		end else if (clk_en_i) begin
			r <= next_r;
		end
	end

	// memory arrays
	always_ff @(posedge clock_i) begin
		if (clk_en_i) begin
			if (fl_we) flash[fl_wa] <= fl_wd;
			if (ee_we) eep[ee_wa] <= ee_wd;
			if (pb_we) pbuf[pb_wa] <= pb_wd;
			if (eb_we) ebuf[pb_wa[EP_AW-1:0]] <= pb_wd[7:0];
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	a_cmd_load_take: assert property (clk_en_i && r.mode == hvpp_pkg::MODE_ACTIVE && xtal_rise &&
		{r.s2.xa1, r.s2.xa0} == 2'h2 |=> r.cmd == $past(r.s2.data)) else $error("command not loaded");
	a_cmd_hold: assert property (clk_en_i && !xtal_rise |=> $stable(r.cmd))
		else $error("command changed without load");
	a_addr_hi_sel: assert property (clk_en_i && r.mode == hvpp_pkg::MODE_ACTIVE && xtal_rise &&
		{r.s2.xa1, r.s2.xa0} == 2'h0 && r.s2.bs1 |=> r.addr_hi == $past(r.s2.data) && $stable(r.addr_lo))
		else $error("address high byte not loaded");
	a_data_lo_sel: assert property (clk_en_i && r.mode == hvpp_pkg::MODE_ACTIVE && xtal_rise &&
		{r.s2.xa1, r.s2.xa0} == 2'h1 && !r.s2.bs1 |=> r.dat_lo == $past(r.s2.data) && $stable(r.dat_hi))
		else $error("data low byte not loaded");
	a_erase_busy: assert property (clk_en_i && r.mode == hvpp_pkg::MODE_ACTIVE && wr_fall &&
		r.op == hvpp_pkg::OP_NONE && r.cmd == 8'h80 |=> !ready_busy_out_o) else $error("erase not busy");
	a_lock_late: assert property (r.op == hvpp_pkg::OP_ERASE |=> r.lock == $past(r.lock))
		else $error("lock cleared during flash erase");
	a_fuse_keep: assert property (r.op == hvpp_pkg::OP_ERASE |=> $stable(r.fuse_hi) &&
		$stable(r.fuse_lo)) else $error("fuses changed by erase");
	a_oe_release: assert property (clk_en_i && r.s2.oe_n |=> !data_oe_o)
		else $error("bus driven with output enable high");
	a_busy_cause: assert property ($fell(ready_busy_out_o) |-> $past(wr_fall) || r.fcnt == 2'h2)
		else $error("busy without write strobe or full buffer");
	a_entry_hold: assert property ($rose(prog_mode_o) |-> $past(r.mode) == hvpp_pkg::MODE_ENTRY &&
		$past(r.ent_cnt) == 16'(`HVPP_ENTRY_CYC - 1)) else $error("entry without full hold");
	c_erase: cover property (r.op == hvpp_pkg::OP_LOCKCLR);
	c_page: cover property (r.op == hvpp_pkg::OP_PAGE ##1 r.op == hvpp_pkg::OP_PAGE);
	c_read: cover property (data_oe_o && r.cmd == 8'h02);
	c_full: cover property (r.fcnt == 2'h2);
endmodule : hvpp_port

// >>> verif/hvpp_prog_model.sv
// external programmer driving the parallel port pins
module hvpp_prog_model (
	input  wire logic       clock_i, // bench clock
	input  wire logic       ready_i, // device ready
	input  wire logic       prog_i,  // device in mode
	input  wire logic       oe_i,    // device drives bus
	input  wire logic [7:0] bus_i,   // resolved bus
	output logic            hv_o,    // high voltage
	output logic            xtal_o,  // load pulse
	output logic [1:0]      act_o,   // action bits
	output logic            bs1_o,   // byte select
	output logic            bs2_o,   // byte select ext
	output logic            page_buffer_latch_o, // page latch
	output logic            wr_n_o,  // write strobe
	output logic            oe_n_o,  // output enable
	output logic [7:0]      dout_o   // bus drive value
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle pins, entry signature all zero
	initial begin
		{hv_o, xtal_o, act_o, bs1_o, bs2_o, page_buffer_latch_o, dout_o} = '0;
		wr_n_o = 1'b1;
		oe_n_o = 1'b1;
	end
	// step clock edges, drive just after
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : tick
	// signature held until the mode latches
	task automatic enter(output int n);
		hv_o = 1'b1;
		n = 0;
		while (n < 1200 && prog_i !== 1'b1) begin
			tick(1);
			n++;
		end
		tick(30000);
	endtask : enter
	// byte select set up, pulse of 25 cycles
	task automatic load(input logic [1:0] a, input logic b1, input logic [7:0] v);
		act_o = a;
		bs1_o = b1;
		bs2_o = 1'b0;
		dout_o = v;
		tick(25);
		xtal_o = 1'b1;
		tick(25);
		xtal_o = 1'b0;
		tick(25);
	endtask : load
	task automatic latch(input logic b1);
		bs1_o = b1;
		tick(25);
		page_buffer_latch_o = 1'b1;
		tick(25);
		page_buffer_latch_o = 1'b0;
		tick(25);
	endtask : latch
	// write pulse, then wait for ready
	task automatic write_op(input logic b1, input logic b2, output logic busy,
		output logic done);
		bs1_o = b1;
		bs2_o = b2;
		busy = 1'b0;
		done = 1'b0;
		tick(25);
		wr_n_o = 1'b0;
		for (int i = 0; i < 25; i++) begin
			tick(1);
			if (ready_i === 1'b0) busy = 1'b1;
		end
		wr_n_o = 1'b1;
		for (int i = 0; i < 2000 && !done; i++) begin
			tick(1);
			if (ready_i === 1'b1) done = 1'b1;
		end
	endtask : write_op
	// bus released by us while output enable low
	task automatic read(input logic b1, input logic b2, output logic [7:0] v,
		output logic oe);
		bs1_o = b1;
		bs2_o = b2;
		oe_n_o = 1'b0;
		tick(25);
		v = bus_i;
		oe = oe_i;
		oe_n_o = 1'b1;
		tick(25);
	endtask : read
endmodule : hvpp_prog_model

// >>> verif/hvpp_port_tb.sv
`include "hvpp_params.svh"
module hvpp_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] S0  = 8'h3c; // arbitrary value
	localparam logic [7:0] S1  = 8'h6e; // arbitrary value
	localparam logic [7:0] S2  = 8'h71; // arbitrary value
	localparam logic [7:0] CAL = 8'h4b; // arbitrary value
	logic       clock;
	logic       rst_n = 1'b0;
	logic       clk_en = 1'b1; // clock enable
	logic       hv, xtal, bs1, bs2, page_buffer_latch, wr_n, oe_n;
	logic [1:0] act;
	logic [7:0] dout, data_o, bus;
	logic [7:0] last_bus = 8'h00; // last bus level
	logic       data_oe, ready, prog, preserve;
	int         bad_count = 0;
	int         check_count = 0;
	// undriven bus shows the inverse of its last level
	assign bus = data_oe ? data_o : (!oe_n ? ~last_bus : dout);
	always @(posedge clock) last_bus <= bus;
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	hvpp_port #(.FLASH_AW(6), .PW_AW(3), .SIG0(S0), .SIG1(S1), .SIG2(S2), .CAL(CAL)) u_hvpp_port (
		.clock_i(clock), .rst_n_i(rst_n), .clk_en_i(clk_en), .hv_reset_i(hv),
		.load_pulse_in_i(xtal), .load_action_bit0_i(act[0]), .load_action_bit1_i(act[1]),
		.byte_select_lo_hi_i(bs1), .byte_select_ext_i(bs2), .page_buffer_latch_i(page_buffer_latch),
		.write_n_i(wr_n), .out_en_n_i(oe_n), .data_i(bus), .data_o(data_o),
		.data_oe_o(data_oe), .ready_busy_out_o(ready), .prog_mode_o(prog),
		.eeprom_preserve_fuse_o(preserve));
	hvpp_prog_model u_hvpp_prog_model (
		.clock_i(clock), .ready_i(ready), .prog_i(prog), .oe_i(data_oe), .bus_i(bus),
		.hv_o(hv), .xtal_o(xtal), .act_o(act), .bs1_o(bs1), .bs2_o(bs2), .page_buffer_latch_o(page_buffer_latch),
		.wr_n_o(wr_n), .oe_n_o(oe_n), .dout_o(dout));
	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// one compare
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] v);
		u_hvpp_prog_model.load(a, b, v);
	endtask : ld
	// write pulse must show busy, then ready within bound
	task automatic wr(input logic b1, input logic b2);
		logic busy;
		logic done;
		u_hvpp_prog_model.write_op(b1, b2, busy, done);
		chk("busy", 8'h01, {7'h00, busy});
		if (done !== 1'b1) begin
			bad_count++;
			$display("ERROR ready expected 1 seen %b", ready);
			tally_and_finish();
		end
	endtask : wr
	// read one byte, bus driven then released
	task automatic rd(input logic b1, input logic b2, input logic [7:0] exp);
		logic [7:0] v;
		logic       oe;
		u_hvpp_prog_model.read(b1, b2, v, oe);
		chk("data", exp, v);
		chk("drive", 8'h01, {7'h00, oe});
		chk("release", 8'h00, {7'h00, data_oe});
	endtask : rd
	// mode entry timing
	task automatic t_entry();
		int n;
		chk("mode before", 8'h00, {7'h00, prog});
		u_hvpp_prog_model.enter(n);
		chk("entry", 8'h01, {7'h00, n >= `HVPP_ENTRY_CYC && n <= `HVPP_ENTRY_CYC + 10});
	endtask : t_entry
	// fuse and lock defaults through every byte select
	task automatic t_default();
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_FUSE);
		rd(1'b0, 1'b0, `HVPP_FUSE_LO_RST);
		rd(1'b1, 1'b1, `HVPP_FUSE_HI_RST);
		rd(1'b0, 1'b1, `HVPP_FUSE_EXT_RST);
		rd(1'b1, 1'b0, `HVPP_LOCK_RST);
		chk("preserve", 8'h01, {7'h00, preserve});
	endtask : t_default
	// signature bytes by address, calibration on high select
	task automatic t_sig();
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_SIG);
		for (int i = 0; i < 3; i++) begin
			ld(`HVPP_ACT_ADDR, 1'b0, 8'(i));
			rd(1'b0, 1'b0, i == 0 ? S0 : (i == 1 ? S1 : S2));
		end
		rd(1'b1, 1'b0, CAL);
	endtask : t_sig
	task automatic t_erase();
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_ERASE);
		wr(1'b0, 1'b0);
	endtask : t_erase
	// two words through the page buffer, read back out of order
	task automatic t_flash();
		logic [15:0] w [2];
		w = '{16'hc3a5, 16'h5a0f};
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_WR_FLASH);
		ld(`HVPP_ACT_ADDR, 1'b1, 8'h00);
		for (int i = 0; i < 2; i++) begin
			ld(`HVPP_ACT_ADDR, 1'b0, 8'(i));
			ld(`HVPP_ACT_DATA, 1'b0, w[i][7:0]);
			ld(`HVPP_ACT_DATA, 1'b1, w[i][15:8]);
			u_hvpp_prog_model.latch(1'b1);
		end
		wr(1'b0, 1'b0);
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_NOP);
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_FLASH);
		for (int i = 1; i >= 0; i--) begin
			ld(`HVPP_ACT_ADDR, 1'b0, 8'(i));
			rd(1'b0, 1'b0, w[i][7:0]);
			rd(1'b1, 1'b0, w[i][15:8]);
		end
	endtask : t_flash
	// high fuse with preserve programmed, lock bits programmed
	task automatic t_fuse();
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_WR_FUSE);
		ld(`HVPP_ACT_DATA, 1'b0, 8'hf7);
		wr(1'b1, 1'b0);
		chk("preserve", 8'h00, {7'h00, preserve});
		ld(`HVPP_ACT_DATA, 1'b0, 8'hf8);
		wr(1'b0, 1'b1);
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_WR_LOCK);
		ld(`HVPP_ACT_DATA, 1'b0, 8'hfc);
		wr(1'b0, 1'b0);
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_FUSE);
		rd(1'b1, 1'b0, 8'hfc);
		rd(1'b0, 1'b1, 8'hf8);
		rd(1'b0, 1'b0, `HVPP_FUSE_LO_RST);
	endtask : t_fuse
	// eeprom byte survives erase, locks and flash do not
	task automatic t_ee();
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_WR_EE);
		ld(`HVPP_ACT_ADDR, 1'b1, 8'h00);
		ld(`HVPP_ACT_ADDR, 1'b0, 8'h05);
		ld(`HVPP_ACT_DATA, 1'b0, 8'ha5);
		u_hvpp_prog_model.latch(1'b0);
		wr(1'b0, 1'b0);
		t_erase();
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_FUSE);
		rd(1'b1, 1'b1, 8'hf7);
		rd(1'b1, 1'b0, 8'hff);
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_EE);
		rd(1'b0, 1'b0, 8'ha5);
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_FLASH);
		ld(`HVPP_ACT_ADDR, 1'b0, 8'h01);
		rd(1'b1, 1'b0, 8'hff);
	endtask : t_ee
	// a load pulse given while the clock enable is low is lost
	task automatic t_freeze();
		clk_en = 1'b0;
		ld(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_SIG);
		clk_en = 1'b1;
		rd(1'b1, 1'b0, 8'hff);
		chk("mode", 8'h01, {7'h00, prog});
	endtask : t_freeze
	// main sequence
	initial begin
		repeat (16) @(posedge clock);
		#1;
		rst_n = 1'b1;
		t_entry();
		t_default();
		t_sig();
		t_erase();
		t_flash();
		t_fuse();
		t_ee();
		t_freeze();
		tally_and_finish();
	end
endmodule : hvpp_port_tb
